// ===== common/ifeb_pkg.sv
// package for the interrupt flag and enable bank: map, layouts, carriers
package ifeb_pkg;

	// data and bus widths
	localparam int WORD_W = 16;
	localparam int WB_DAT_W = 32;
	localparam int WB_ADR_W = 8;
	localparam int WB_SEL_W = 4;
	localparam int NUM_REGS = 5;
	localparam int IDX_W = 3;

	// register indices and byte offsets on the bus
	localparam logic [IDX_W-1:0] IDX_FLAGS6 = 3'h0;
	localparam logic [IDX_W-1:0] IDX_FLAGS7 = 3'h1;
	localparam logic [IDX_W-1:0] IDX_EN0 = 3'h2;
	localparam logic [IDX_W-1:0] IDX_EN1 = 3'h3;
	localparam logic [IDX_W-1:0] IDX_EN2 = 3'h4;
	localparam logic [WB_ADR_W-1:0] OFS_FLAGS6 = 8'h00;
	localparam logic [WB_ADR_W-1:0] OFS_FLAGS7 = 8'h04;
	localparam logic [WB_ADR_W-1:0] OFS_EN0 = 8'h08;
	localparam logic [WB_ADR_W-1:0] OFS_EN1 = 8'h0C;
	localparam logic [WB_ADR_W-1:0] OFS_EN2 = 8'h10;

	// reset value and implemented-bit masks; unimplemented bits read zero
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] FLAGS6_MASK = 16'hC3FF;
	localparam logic [WORD_W-1:0] FLAGS7_MASK = 16'h003F;
	localparam logic [WORD_W-1:0] EN0_MASK = 16'h7FFF;
	localparam logic [WORD_W-1:0] EN1_MASK = 16'hFF1F;
	localparam logic [WORD_W-1:0] EN2_MASK = 16'h007F;
	localparam logic [WORD_W-1:0] EN2_CAN_MASK = 16'h000C;
	localparam logic [WB_DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

	// flag word six and seven bit positions
	localparam int F6_ADC_PAIR1 = 15, F6_ADC_PAIR0 = 14, F6_CMP4 = 9, F6_CMP3 = 8,
		F6_CMP2 = 7, F6_PWM9 = 6, F6_PWM3 = 0;
	localparam int F7_ADC_PAIR7 = 5, F7_ADC_PAIR2 = 0;

	// enable word bit positions
	localparam int E0_DMA_CH1 = 14, E0_ADC_DONE = 13, E0_UART1_TX = 12, E0_UART1_RX = 11,
		E0_SPI1_EVENT = 10, E0_SPI1_SECOND = 9, E0_TIMER3 = 8, E0_TIMER2 = 7,
		E0_OUT_CMP2 = 6, E0_IN_CAP2 = 5, E0_DMA_CH0 = 4, E0_TIMER1 = 3,
		E0_OUT_CMP1 = 2, E0_IN_CAP1 = 1, E0_EXT_PIN0 = 0;
	localparam int E1_UART2_TX = 15, E1_UART2_RX = 14, E1_EXT_PIN2 = 13, E1_TIMER5 = 12,
		E1_TIMER4 = 11, E1_OUT_CMP4 = 10, E1_OUT_CMP3 = 9, E1_DMA_CH2 = 8,
		E1_EXT_PIN1 = 4, E1_PIN_CHANGE = 3, E1_CMP1 = 2, E1_I2C1_MASTER = 1,
		E1_I2C1_SLAVE = 0;
	localparam int E2_IN_CAP4 = 6, E2_IN_CAP3 = 5, E2_DMA_CH3 = 4, E2_CAN_EVENT = 3,
		E2_CAN_RX = 2, E2_SPI2_EVENT = 1, E2_SPI2_ERROR = 0;

	// event sources for flag word six, one pulse or level per source
	typedef struct packed {
		logic adc_pair1_done_flag;
		logic adc_pair0_done_flag;
		logic comparator4_flag;
		logic comparator3_flag;
		logic comparator2_flag;
		logic [6:0] pwm_gen_flag;
	} ifeb_src6_t;

	// event sources for flag word seven, adc pairs 7 down to 2
	typedef struct packed {
		logic [5:0] adc_pair_done_flag;
	} ifeb_src7_t;

	// flag and enable words held elsewhere in the controller
	typedef struct packed {
		logic [WORD_W-1:0] flags0;
		logic [WORD_W-1:0] flags1;
		logic [WORD_W-1:0] flags2;
		logic [WORD_W-1:0] en6;
		logic [WORD_W-1:0] en7;
	} ifeb_ext_t;

	// gated requests toward the priority logic
	typedef struct packed {
		logic [WORD_W-1:0] req0;
		logic [WORD_W-1:0] req1;
		logic [WORD_W-1:0] req2;
		logic [WORD_W-1:0] req6;
		logic [WORD_W-1:0] req7;
	} ifeb_req_t;

	// one register write, as taken at the acknowledging edge
	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] idx;
		logic [1:0] be;
		logic [WORD_W-1:0] data;
	} ifeb_wr_t;

	typedef logic [NUM_REGS-1:0][WORD_W-1:0] ifeb_words_t;

	// byte address to register index; ok low for unmapped addresses
	function automatic logic [IDX_W:0] ifeb_decode(input logic [WB_ADR_W-1:0] adr);
		logic [IDX_W:0] res;
		res = {1'b0, IDX_FLAGS6};
		unique case (adr)
			OFS_FLAGS6: res = {1'b1, IDX_FLAGS6};
			OFS_FLAGS7: res = {1'b1, IDX_FLAGS7};
			OFS_EN0: res = {1'b1, IDX_EN0};
			OFS_EN1: res = {1'b1, IDX_EN1};
			OFS_EN2: res = {1'b1, IDX_EN2};
			default: res = {1'b0, IDX_FLAGS6};
		endcase
		return res;
	endfunction : ifeb_decode

	// implemented bits per register index
	function automatic logic [WORD_W-1:0] ifeb_mask(input int idx, input bit has_can);
		logic [WORD_W-1:0] m;
		m = WORD_RESET;
		unique case (idx)
			0: m = FLAGS6_MASK;
			1: m = FLAGS7_MASK;
			2: m = EN0_MASK;
			3: m = EN1_MASK;
			default: m = has_can ? EN2_MASK : (EN2_MASK & ~EN2_CAN_MASK);
		endcase
		return m;
	endfunction : ifeb_mask

endpackage : ifeb_pkg

// ===== design/ifeb_reg_word.sv
// one 16-bit register word with byte writes, hardware set and fixed zero bits
`timescale 1ns/1ps
`default_nettype none
module ifeb_reg_word
	import ifeb_pkg::*;
#(
	parameter logic [ifeb_pkg::WORD_W-1:0] MASK = 16'hFFFF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// hardware events, one bit per source
	input wire logic [ifeb_pkg::WORD_W-1:0] set_i,
	// software write
	input wire logic wr_i,
	input wire logic [1:0] be_i,
	input wire logic [ifeb_pkg::WORD_W-1:0] wdata_i,
	// held value
	output logic [ifeb_pkg::WORD_W-1:0] q_o
);
	logic [WORD_W-1:0] q;
	logic [WORD_W-1:0] next_q;

	// write by byte lane, then or in events so a same-cycle set beats a clear
	always_comb begin
		next_q = q;
		if (wr_i && be_i[0]) begin
			next_q[7:0] = wdata_i[7:0];
		end
		if (wr_i && be_i[1]) begin
			next_q[15:8] = wdata_i[15:8];
		end
		next_q = (next_q | set_i) & MASK;
	end

	// power-on value is all zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= WORD_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign q_o = q;
endmodule : ifeb_reg_word
`default_nettype wire

// ===== design/ifeb_wb_slave.sv
// classic wishbone slave front end for the flag and enable words
`timescale 1ns/1ps
`default_nettype none
module ifeb_wb_slave
	import ifeb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone request
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ifeb_pkg::WB_ADR_W-1:0] adr_i,
	input wire logic [ifeb_pkg::WB_SEL_W-1:0] sel_i,
	input wire logic [ifeb_pkg::WB_DAT_W-1:0] dat_i,
	// wishbone answer
	output logic ack_o,
	output logic [ifeb_pkg::WB_DAT_W-1:0] dat_o,
	// register side
	input wire ifeb_pkg::ifeb_words_t words_i,
	output ifeb_pkg::ifeb_wr_t wr_o
);
	logic ack;
	logic [WB_DAT_W-1:0] dat;
	logic next_ack;
	logic [WB_DAT_W-1:0] next_dat;
	logic [IDX_W:0] dec;

	// one wait state: ack a cycle after the request, drop it the cycle after
	always_comb begin
		dec = ifeb_decode(adr_i);
		next_ack = cyc_i && stb_i && !ack;
		next_dat = DAT_ZERO;
		if (next_ack && dec[IDX_W]) begin
			next_dat = {16'h0000, words_i[dec[IDX_W-1:0]]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat <= DAT_ZERO;
		end else begin
			ack <= next_ack;
			dat <= next_dat;
		end
	end

	// writes land at the acknowledging edge; unmapped writes are acked and dropped
	always_comb begin
		wr_o.valid = cyc_i && stb_i && we_i && ack && dec[IDX_W];
		wr_o.idx = dec[IDX_W-1:0];
		wr_o.be = sel_i[1:0];
		wr_o.data = dat_i[WORD_W-1:0];
	end

	assign ack_o = ack;
	assign dat_o = dat;
endmodule : ifeb_wb_slave
`default_nettype wire

// ===== design/ifeb_top.sv
// interrupt flag and enable bank: flag words six and seven, enable words zero to two
//
// Notes on behaviour
// - a source event sets its flag to one; zero means nothing happened
// - an enable at one passes its source's request, at zero blocks it
// - flag word six bits 15 and 14 hold adc pair 1 and pair 0 done
// - flag word six bits 9..7 hold comparators 4..2; bits 13..10 read zero
// - flag word six bits 6..0 hold pwm generators 9..3, bit 0 is generator 3
// - flag word seven bits 5..0 hold adc pairs 7..2; bits 15..6 read zero
// - enable word zero bits 14..8: dma1, adc, uart1 tx/rx, spi1 two bits, timer3
// - enable word zero bits 7..0: timer2, oc2, ic2, dma0, timer1, oc1, ic1, pin0
// - enable word zero bit 15 is unimplemented and reads zero
// - enable word one upper byte: uart2 tx/rx, pin2, timers 5/4, oc4, oc3, dma2
// - enable word one bits 7..5 read zero; bits 4..0 pin1, change, cmp1, i2c1
// - enable word two bits 15..7 zero; 6..0 ic4, ic3, dma3, can two, spi2 two
// - without a can controller the can enables stay disabled
// - every implemented bit resets to zero and is read and write by software
`timescale 1ns/1ps
`default_nettype none
module ifeb_top
	import ifeb_pkg::*;
#(
	parameter bit HAS_CAN = 1'b1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ifeb_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [ifeb_pkg::WB_SEL_W-1:0] wb_sel_i,
	input wire logic [ifeb_pkg::WB_DAT_W-1:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [ifeb_pkg::WB_DAT_W-1:0] wb_dat_o,
	// peripheral event sources, same clock
	input wire ifeb_pkg::ifeb_src6_t src6_i,
	input wire ifeb_pkg::ifeb_src7_t src7_i,
	// companion flag and enable words from the rest of the controller
	input wire ifeb_pkg::ifeb_ext_t ext_i,
	// gated requests toward the priority logic
	output ifeb_pkg::ifeb_req_t req_o
);
	ifeb_words_t words;
	ifeb_words_t sets;
	ifeb_wr_t wr;
	ifeb_req_t req;
	ifeb_req_t next_req;

	// bus front end; answers every request one cycle later
	ifeb_wb_slave u_wb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.we_i(wb_we_i),
		.adr_i(wb_adr_i),
		.sel_i(wb_sel_i),
		.dat_i(wb_dat_i),
		.ack_o(wb_ack_o),
		.dat_o(wb_dat_o),
		.words_i(words),
		.wr_o(wr)
	);

	// map each source onto its bit; enable words have no hardware set
	always_comb begin
		sets = '0;
		sets[IDX_FLAGS6][F6_ADC_PAIR1] = src6_i.adc_pair1_done_flag;
		sets[IDX_FLAGS6][F6_ADC_PAIR0] = src6_i.adc_pair0_done_flag;
		sets[IDX_FLAGS6][F6_CMP4] = src6_i.comparator4_flag;
		sets[IDX_FLAGS6][F6_CMP3] = src6_i.comparator3_flag;
		sets[IDX_FLAGS6][F6_CMP2] = src6_i.comparator2_flag;
		sets[IDX_FLAGS6][F6_PWM9:F6_PWM3] = src6_i.pwm_gen_flag;
		sets[IDX_FLAGS7][F7_ADC_PAIR7:F7_ADC_PAIR2] = src7_i.adc_pair_done_flag;
	end

	// the five words; masks pin unimplemented bits and absent can bits to zero
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
		ifeb_reg_word #(
			.MASK(ifeb_mask(i, HAS_CAN))
		) u_word (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.set_i(sets[i]),
			.wr_i(wr.valid && (wr.idx == IDX_W'(i))),
			.be_i(wr.be),
			.wdata_i(wr.data),
			.q_o(words[i])
		);
	end

	// a request leaves only where flag and enable agree
	always_comb begin
		next_req.req0 = ext_i.flags0 & words[IDX_EN0];
		next_req.req1 = ext_i.flags1 & words[IDX_EN1];
		next_req.req2 = ext_i.flags2 & words[IDX_EN2];
		next_req.req6 = words[IDX_FLAGS6] & ext_i.en6;
		next_req.req7 = words[IDX_FLAGS7] & ext_i.en7;
	end

	// registered so the priority logic sees a clean, glitch-free level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req <= '0;
		end else begin
			req <= next_req;
		end
	end

	assign req_o = req;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// a full-width write to one register, taken at the ack edge
	sequence s_full_write(logic [IDX_W-1:0] idx);
		wr.valid && wr.idx == idx && wr.be == 2'b11;
	endsequence

	// a request placed on the bus but not yet answered
	sequence s_new_request;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	AST_ADC1_SETS_BIT15: assert property (
		src6_i.adc_pair1_done_flag |=> words[IDX_FLAGS6][F6_ADC_PAIR1]
	) else $error("adc pair 1 event did not set flag word six bit 15");

	AST_ADC0_SETS_BIT14: assert property (
		src6_i.adc_pair0_done_flag |=> words[IDX_FLAGS6][F6_ADC_PAIR0]
	) else $error("adc pair 0 event did not set flag word six bit 14");

	AST_CMP_SETS_BITS: assert property (
		src6_i.comparator4_flag && src6_i.comparator2_flag
			|=> words[IDX_FLAGS6][F6_CMP4] && words[IDX_FLAGS6][F6_CMP2]
	) else $error("comparator event did not set its flag");

	AST_FLAGS6_GAP_ZERO: assert property (
		words[IDX_FLAGS6][13:10] == 4'h0
	) else $error("flag word six bits 13..10 not zero");

	AST_PWM3_SETS_BIT0: assert property (
		src6_i.pwm_gen_flag[0] |=> words[IDX_FLAGS6][F6_PWM3]
	) else $error("pwm generator 3 event did not set bit 0");

	AST_PWM9_SETS_BIT6: assert property (
		src6_i.pwm_gen_flag[6] |=> words[IDX_FLAGS6][F6_PWM9]
	) else $error("pwm generator 9 event did not set bit 6");

	AST_FLAGS7_MAP: assert property (
		src7_i.adc_pair_done_flag[5] && src7_i.adc_pair_done_flag[0]
			|=> words[IDX_FLAGS7][F7_ADC_PAIR7] && words[IDX_FLAGS7][F7_ADC_PAIR2]
				&& words[IDX_FLAGS7][15:6] == 10'h000
	) else $error("flag word seven mapping wrong");

	AST_SET_BEATS_CLEAR: assert property (
		s_full_write(IDX_FLAGS6) ##0 (wr.data[F6_ADC_PAIR1] == 1'b0)
			##0 src6_i.adc_pair1_done_flag
			|=> words[IDX_FLAGS6][F6_ADC_PAIR1]
	) else $error("event lost against a clearing write");

	AST_EN0_WRITE_READBACK: assert property (
		s_full_write(IDX_EN0) |=> words[IDX_EN0] == ($past(wr.data) & EN0_MASK)
	) else $error("enable word zero did not take the written value");

	AST_EN1_WRITE_READBACK: assert property (
		s_full_write(IDX_EN1) |=> words[IDX_EN1] == ($past(wr.data) & EN1_MASK)
	) else $error("enable word one did not take the written value");

	AST_EN2_UPPER_ZERO: assert property (
		words[IDX_EN2][15:7] == 9'h000
	) else $error("enable word two bits 15..7 not zero");

	AST_CAN_DISABLED: assert property (
		!HAS_CAN |-> (words[IDX_EN2] & EN2_CAN_MASK) == WORD_RESET
	) else $error("can enable set on a part without can");

	AST_ENABLE_PASSES: assert property (
		(ext_i.flags0[E0_TIMER1] && words[IDX_EN0][E0_TIMER1]) |=> req.req0[E0_TIMER1]
	) else $error("enabled request not forwarded");

	AST_DISABLED_BLOCKS: assert property (
		!words[IDX_EN1][E1_UART2_TX] |=> !req.req1[E1_UART2_TX]
	) else $error("disabled request forwarded");

	AST_EVENT_TO_REQUEST: assert property (
		(src6_i.adc_pair0_done_flag && ext_i.en6[F6_ADC_PAIR0]) ##1 ext_i.en6[F6_ADC_PAIR0]
			|=> req.req6[F6_ADC_PAIR0]
	) else $error("flagged and enabled source gave no request");

	AST_RESET_CLEARS: assert property (
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> words == '0 && req == '0
	) else $error("words not zero after reset");

	AST_ACK_ONE_CYCLE: assert property (
		s_new_request |=> wb_ack_o ##1 !wb_ack_o
	) else $error("bus answer not a single cycle after one wait");

	// address decode as the checks below see it
	logic [IDX_W:0] adr_dec;
	assign adr_dec = ifeb_decode(wb_adr_i);

	// an answered read of one mapped word
	sequence s_read_ack(logic [IDX_W-1:0] idx);
		wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o && adr_dec == {1'b1, idx};
	endsequence

	// an answered request to an address that maps to no word
	sequence s_unmapped_ack;
		wb_cyc_i && wb_stb_i && wb_ack_o && !adr_dec[IDX_W];
	endsequence

	// read data was captured one edge earlier, so compare against the past word
	AST_READ_FLAGS6: assert property (
		s_read_ack(IDX_FLAGS6) |-> wb_dat_o == {WORD_RESET, $past(words[IDX_FLAGS6])}
	) else $error("flag word six read back wrong");

	AST_READ_FLAGS7: assert property (
		s_read_ack(IDX_FLAGS7) |-> wb_dat_o == {WORD_RESET, $past(words[IDX_FLAGS7])}
	) else $error("flag word seven read back wrong");

	AST_READ_EN0: assert property (
		s_read_ack(IDX_EN0) |-> wb_dat_o == {WORD_RESET, $past(words[IDX_EN0])}
	) else $error("enable word zero read back wrong");

	AST_READ_EN1: assert property (
		s_read_ack(IDX_EN1) |-> wb_dat_o == {WORD_RESET, $past(words[IDX_EN1])}
	) else $error("enable word one read back wrong");

	AST_READ_EN2: assert property (
		s_read_ack(IDX_EN2) |-> wb_dat_o == {WORD_RESET, $past(words[IDX_EN2])}
	) else $error("enable word two read back wrong");

	AST_UNMAPPED_READ_ZERO: assert property (
		s_unmapped_ack |-> wb_dat_o == DAT_ZERO
	) else $error("unmapped address returned data");

	// events are excluded so that only the bus could have changed a word
	AST_UNMAPPED_WRITE_DROPPED: assert property (
		s_unmapped_ack ##0 (wb_we_i && src6_i == '0 && src7_i == '0)
			|=> words == $past(words)
	) else $error("unmapped write changed a word");

	AST_DAT_ZERO_IDLE: assert property (
		!wb_ack_o |-> wb_dat_o == DAT_ZERO
	) else $error("read data not zero outside the answer");

	AST_NO_ACK_IDLE: assert property (
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o
	) else $error("answer given with no request");

	// a flag is sticky: only an event or a write may move it
	AST_FLAGS6_HOLD: assert property (
		!(wr.valid && wr.idx == IDX_FLAGS6) && src6_i == '0
			|=> $stable(words[IDX_FLAGS6])
	) else $error("flag word six changed by itself");

	AST_FLAGS7_HOLD: assert property (
		!(wr.valid && wr.idx == IDX_FLAGS7) && src7_i == '0
			|=> $stable(words[IDX_FLAGS7])
	) else $error("flag word seven changed by itself");

	AST_FLAGS6_WRITE_READBACK: assert property (
		s_full_write(IDX_FLAGS6) ##0 src6_i == '0
			|=> words[IDX_FLAGS6] == ($past(wr.data) & FLAGS6_MASK)
	) else $error("flag word six did not take the written value");

	AST_FLAGS7_WRITE_READBACK: assert property (
		s_full_write(IDX_FLAGS7) ##0 src7_i == '0
			|=> words[IDX_FLAGS7] == ($past(wr.data) & FLAGS7_MASK)
	) else $error("flag word seven did not take the written value");

	AST_EN2_WRITE_READBACK: assert property (
		s_full_write(IDX_EN2) |=> words[IDX_EN2]
			== ($past(wr.data) & EN2_MASK & (HAS_CAN ? EN2_MASK : ~EN2_CAN_MASK))
	) else $error("enable word two did not take the written value");

	AST_LOW_LANE_ONLY: assert property (
		wr.valid && wr.idx == IDX_EN1 && wr.be == 2'b01
			|=> $stable(words[IDX_EN1][15:8])
	) else $error("low byte write touched the high byte");

	AST_REQ2_FOLLOWS: assert property (
		1'b1 |=> req.req2 == ($past(ext_i.flags2) & $past(words[IDX_EN2]))
	) else $error("word two requests do not follow flag and enable");

	AST_REQ6_FOLLOWS: assert property (
		1'b1 |=> req.req6 == ($past(words[IDX_FLAGS6]) & $past(ext_i.en6))
	) else $error("word six requests do not follow flag and enable");

	AST_REQ7_FOLLOWS: assert property (
		1'b1 |=> req.req7 == ($past(words[IDX_FLAGS7]) & $past(ext_i.en7))
	) else $error("word seven requests do not follow flag and enable");

endmodule : ifeb_top
`default_nettype wire

// ===== dv/ifeb_src_model.sv
// behavioural model of the peripheral event sources that feed the bank
`timescale 1ns/1ps
`default_nettype none
module ifeb_src_model
	import ifeb_pkg::*;
(
	// command from the bench
	input wire logic fire_i,
	input wire logic [11:0] pat6_i,
	input wire logic [5:0] pat7_i,
	// event lines toward the bank
	output var ifeb_pkg::ifeb_src6_t src6_o,
	output var ifeb_pkg::ifeb_src7_t src7_o
);
	// lines are low outside a pulse so a stale pattern can never set a flag twice
	assign src6_o = fire_i ? ifeb_src6_t'(pat6_i) : '0;
	assign src7_o = fire_i ? ifeb_src7_t'(pat7_i) : '0;
endmodule : ifeb_src_model
`default_nettype wire

// ===== dv/irq_flag_enable_bank_bench.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable_bank_bench;
	import ifeb_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic ack;
	logic [31:0] rdat;
	logic fire = 1'b0;
	logic [11:0] pat6 = 12'h000;
	logic [5:0] pat7 = 6'h00;
	ifeb_src6_t src6;
	ifeb_src7_t src7;
	ifeb_ext_t ext = '0;
	ifeb_req_t req;
	ifeb_req_t req_nc;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [15:0] msk [5] = '{16'hC3FF, 16'h003F, 16'h7FFF, 16'hFF1F, 16'h007F};

	// 40 MHz core clock
	always #12.5 clk_i = ~clk_i;

	// bank under test and a variant built without the can controller
	ifeb_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
		.wb_dat_o(rdat), .src6_i(src6), .src7_i(src7), .ext_i(ext), .req_o(req));
	ifeb_top #(.HAS_CAN(1'b0)) uut_nocan (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_ack_o(), .wb_dat_o(), .src6_i(src6), .src7_i(src7), .ext_i(ext), .req_o(req_nc));
	ifeb_src_model srcs (.fire_i(fire), .pat6_i(pat6), .pat7_i(pat7), .src6_o(src6),
		.src7_o(src7));

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	// a hang counts as a mismatch
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one classic cycle; request held until ack is sampled high at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [15:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		if (k >= 20)
			n_fail++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
		logic [31:0] q;
		wb(1'b1, a, s, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 4'h3, 16'h0000, q);
		check(q, exp);
	endtask : rd_chk

	// one-cycle pulse on the chosen sources
	task automatic pulse(input logic [11:0] p6, input logic [5:0] p7);
		@(posedge clk_i);
		fire <= 1'b1;
		pat6 <= p6;
		pat7 <= p7;
		@(posedge clk_i);
		fire <= 1'b0;
	endtask : pulse

	task automatic settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask : settle

	task automatic t_reset();
		for (int i = 0; i < 5; i++)
			rd_chk(ofs[i], 32'h0000_0000);
		check(32'(req[15:0]), 32'h0000_0000);
	endtask : t_reset

	// all ones then all zeros: only implemented bits stick
	task automatic t_masks();
		for (int i = 0; i < 5; i++) begin
			wr(ofs[i], 4'h3, 16'hFFFF);
			rd_chk(ofs[i], {16'h0000, msk[i]});
			wr(ofs[i], 4'h3, 16'h0000);
			rd_chk(ofs[i], 32'h0000_0000);
		end
	endtask : t_masks

	// byte lanes write separately; stray addresses are acked and dropped
	task automatic t_bytes_unmapped();
		wr(8'h0C, 4'h1, 16'hFFFF);
		rd_chk(8'h0C, 32'h0000_001F);
		wr(8'h0C, 4'h2, 16'hFFFF);
		rd_chk(8'h0C, 32'h0000_FF1F);
		wr(8'h0C, 4'h3, 16'h0000);
		wr(8'h14, 4'h3, 16'hFFFF);
		wr(8'h02, 4'h3, 16'hFFFF);
		rd_chk(8'h14, 32'h0000_0000);
		rd_chk(8'h00, 32'h0000_0000);
	endtask : t_bytes_unmapped

	// each source alone sets its own bit, which stays until written to zero
	task automatic t_events();
		for (int i = 0; i < 12; i++) begin
			pulse(12'(1 << i), 6'h00);
			rd_chk(8'h00, (i < 10) ? 32'(1 << i) : 32'(1 << (i + 4)));
			wr(8'h00, 4'h3, 16'h0000);
			rd_chk(8'h00, 32'h0000_0000);
		end
		for (int j = 0; j < 6; j++) begin
			pulse(12'h000, 6'(1 << j));
			rd_chk(8'h04, 32'(1 << j));
			wr(8'h04, 4'h3, 16'h0000);
		end
	endtask : t_events

	// a clearing write and an event land on the same edge: the event wins
	task automatic t_set_clear();
		pulse(12'h801, 6'h00);
		fork
			wr(8'h00, 4'h3, 16'h0000);
			begin
				repeat (2) @(posedge clk_i);
				fire <= 1'b1;
				pat6 <= 12'h800;
				@(posedge clk_i);
				fire <= 1'b0;
			end
		join
		rd_chk(8'h00, 32'h0000_8000);
		wr(8'h00, 4'h3, 16'h0000);
		rd_chk(8'h00, 32'h0000_0000);
	endtask : t_set_clear

	// requests leave only where flag and enable are both set
	task automatic t_gate();
		wr(8'h08, 4'h3, 16'hFFFF);
		wr(8'h0C, 4'h3, 16'hFFFF);
		wr(8'h10, 4'h3, 16'hFFFF);
		@(posedge clk_i);
		ext <= '{flags0: 16'hFFFF, flags1: 16'hFFFF, flags2: 16'hFFFF, en6: 16'h0000,
			en7: 16'hFFFF};
		pulse(12'h281, 6'h21);
		settle();
		check(32'(req.req0), 32'h0000_7FFF);
		check(32'(req.req1), 32'h0000_FF1F);
		check(32'(req.req2), 32'h0000_007F);
		check(32'(req_nc.req2), 32'h0000_0073);
		check(32'(req.req6), 32'h0000_0000);
		check(32'(req.req7), 32'h0000_0021);
		@(posedge clk_i);
		ext.en6 <= 16'hFFFF;
		settle();
		check(32'(req.req6), 32'h0000_0281);
		pulse(12'h400, 6'h00);
		settle();
		check(32'(req.req6), 32'h0000_4281);
		wr(8'h04, 4'h3, 16'h0000);
		settle();
		check(32'(req.req7), 32'h0000_0000);
	endtask : t_gate

	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_masks();
		t_bytes_unmapped();
		t_events();
		t_set_clear();
		t_gate();
		summarize();
	end
endmodule : irq_flag_enable_bank_bench
`default_nettype wire
